// ### rtl/ssa_pkg.sv
// Purpose: shared constants and types for the scan shift alignment control block
// Assumes: 32-bit Avalon-MM register bus, word-aligned byte addresses
// Notes:   one system clock, core_clk at 20 MHz
package ssa_pkg;

  // ==========================================================================
  // bus and register map
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_PRIMARY   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_SECONDARY = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_TERTIARY  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_TX_DATA   = 4'hC;
  // reads of the last word return status and the received byte
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 4'hC;
  localparam logic [DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;

  // ==========================================================================
  // primary config fields
  localparam int unsigned PRI_TCK_EN  = 0;
  localparam int unsigned PRI_TDO_EN  = 3;
  localparam int unsigned PRI_TDI_EN  = 4;
  localparam int unsigned PRI_LOCK_LO = 3;
  localparam int unsigned PRI_LOCK_HI = 7;
  // secondary config fields
  localparam int unsigned SEC_LOCK_LO = 3;
  localparam int unsigned SEC_LOCK_HI = 4;
  // tertiary config fields
  localparam int unsigned TER_LOCK    = 0;

  // status fields
  localparam int unsigned ST_TCK_ON  = 0;
  localparam int unsigned ST_TX_FULL = 1;
  localparam int unsigned ST_RX_FULL = 2;
  localparam int unsigned ST_TDI_PIN = 3;
  localparam int unsigned ST_CNT_LO  = 4;
  localparam int unsigned ST_CNT_HI  = 6;
  localparam int unsigned ST_RX_LO   = 8;
  localparam int unsigned ST_RX_HI   = 15;

  // ==========================================================================
  // alignment
  localparam int unsigned      CNT_W    = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
  localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
  localparam int unsigned      BYTE_W   = 8;
  localparam logic [7:0]       RST_CFG  = 8'h00;

  // bus answer states
  typedef enum logic [1:0] {
    SSA_BUS_IDLE = 2'b01,
    SSA_BUS_DONE = 2'b10
  } ssa_bus_t;

endpackage

// ### rtl/ssa_in_sync.sv
// Purpose: three-stage synchroniser for a pin input
// Assumes: the pin is asynchronous to core_clk
// Notes:   a change is taken once stages two and three agree
`timescale 1ns/1ps
module ssa_in_sync (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // pin and result
  input  wire logic pin_in,
  output logic      level_out
);

  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       level_q;
  logic       level_d;

  always_comb begin
    stage_d = {stage_q[1:0], pin_in};
    level_d = level_q;
    if (stage_q[1] == stage_q[2]) begin
      level_d = stage_q[2];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_q <= 3'h0;
      level_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;

endmodule

// ### rtl/ssa_tck_gate.sv
// Purpose: glitch-free gating of the system clock into the test clock
// Assumes: enable comes from core_clk logic, changes after rising edges
// Notes:   enable is latched while the clock is low so tck never chops
`timescale 1ns/1ps
module ssa_tck_gate (
  // clock
  input  wire logic core_clk,
  // control
  input  wire logic run_en,
  // test clock out
  output logic      tck_out
);

  logic en_lat;

  // transparent while clock is low
  always_latch begin
    if (!core_clk) begin
      en_lat <= run_en;
    end
  end

  assign tck_out = core_clk & en_lat;

endmodule

// ### rtl/ssa_shift_align.sv
// Purpose: test clock gating and byte alignment of the scan shifters
// Assumes: host keeps shift-enabling config fields still while tck runs
// Notes:   tdi is sampled on core_clk, never on the generated tck
`timescale 1ns/1ps

// ============================================================================
// Summary of operation
// - test clock is gated system clock
// - sample returning tdi on core_clk rise
// - receive shift gated by fill and config
// - three-bit counter keeps shifters byte aligned
// - late tdo enable at three sends five bits
module ssa_shift_align
  import ssa_pkg::*;
(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_b,
  // avalon-mm slave
  input  wire logic [ssa_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [ssa_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [ssa_pkg::DATA_W-1:0]      avs_readdata,
  output logic                            avs_waitrequest,
  // scan link
  output logic                            tck,
  output logic                            tdo,
  input  wire logic                       tdi,
  // status
  output logic                            lock_violation
);

  import ssa_pkg::*;

  // ==========================================================================
  // registers
  logic [7:0]       pri_q, pri_d;
  logic [7:0]       sec_q, sec_d;
  logic [7:0]       ter_q, ter_d;
  logic [7:0]       tx_hold_q, tx_hold_d;
  logic             tx_full_q, tx_full_d;
  logic [7:0]       tx_sh_q, tx_sh_d;
  logic             tx_act_q, tx_act_d;
  logic [CNT_W-1:0] tx_left_q, tx_left_d;
  logic [7:0]       rx_sh_q, rx_sh_d;
  logic [7:0]       rx_buf_q, rx_buf_d;
  logic             rx_full_q, rx_full_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             run_q, run_d;
  logic             viol_q, viol_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  ssa_bus_t         bus_q, bus_d;

  logic tdi_s;
  logic shift_en;
  logic tx_en;
  logic rx_en;
  logic wr_go;
  logic rd_go;
  logic wr_pri;
  logic wr_sec;
  logic wr_ter;
  logic wr_tx;
  logic rd_st;
  logic tx_last;
  logic rx_last;
  logic tx_ready;
  logic rx_ready;
  logic [7:0] locked_pri;

  // ==========================================================================
  // helpers
  function automatic logic [7:0] merge_lane(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic       be);
    merge_lane = be ? new_v : old_v;
  endfunction

  function automatic logic [7:0] lock_mask_pri();
    logic [7:0] m;
    m = 8'h00;
    for (int i = PRI_LOCK_LO; i <= PRI_LOCK_HI; i++) begin
      m[i] = 1'b1;
    end
    lock_mask_pri = m;
  endfunction

  // the counter value at which a byte boundary falls
  function automatic logic byte_end(input logic [CNT_W-1:0] cnt_v);
    byte_end = (cnt_v == CNT_LAST);
  endfunction

  // ==========================================================================
  // filtered copy of the tdi pin, reported in status only; its three-stage
  // latency and agreement filter would lose bits at the tck rate
  ssa_in_sync u_tdi_sync (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .pin_in    (tdi),
    .level_out (tdi_s)
  );

  // ==========================================================================
  // test clock gating
  ssa_tck_gate u_tck_gate (
    .core_clk (core_clk),
    .run_en   (run_q),
    .tck_out  (tck)
  );

  assign tx_en = pri_q[PRI_TDO_EN];
  assign rx_en = pri_q[PRI_TDI_EN];

  // ==========================================================================
  // bus decode
  // a write lands at the edge that ends its wait; a read is captured when
  // taken so that its data stand in the answer cycle
  assign wr_go      = avs_write && (bus_q == SSA_BUS_DONE);
  assign rd_go      = avs_read && (bus_q == SSA_BUS_IDLE);
  assign wr_pri     = wr_go && (avs_address == OFS_PRIMARY);
  assign wr_sec     = wr_go && (avs_address == OFS_SECONDARY);
  assign wr_ter     = wr_go && (avs_address == OFS_TERTIARY);
  assign wr_tx      = wr_go && (avs_address == OFS_TX_DATA) && avs_byteenable[0];
  assign rd_st      = rd_go && (avs_address == OFS_STATUS);
  assign locked_pri = lock_mask_pri();

  always_comb begin
    bus_d   = bus_q;
    rdata_d = rdata_q;
    case (bus_q)
      SSA_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_d = SSA_BUS_DONE;
        end
        if (rd_go) begin
          case (avs_address)
            OFS_PRIMARY:   rdata_d = {24'h0, pri_q};
            OFS_SECONDARY: rdata_d = {24'h0, sec_q};
            OFS_TERTIARY:  rdata_d = {24'h0, ter_q};
            OFS_STATUS: begin
              rdata_d = UNMAPPED_DATA;
              rdata_d[ST_TCK_ON]             = run_q;
              rdata_d[ST_TX_FULL]            = tx_full_q;
              rdata_d[ST_RX_FULL]            = rx_full_q;
              rdata_d[ST_TDI_PIN]            = tdi_s;
              rdata_d[ST_CNT_HI:ST_CNT_LO]   = cnt_q;
              rdata_d[ST_RX_HI:ST_RX_LO]     = rx_buf_q;
            end
            default:       rdata_d = UNMAPPED_DATA;
          endcase
        end
      end
      SSA_BUS_DONE: bus_d = SSA_BUS_IDLE;
      default:      bus_d = SSA_BUS_IDLE;
    endcase
  end

  // waitrequest high until the answer cycle
  assign avs_waitrequest = (avs_read || avs_write) && (bus_q != SSA_BUS_DONE);
  assign avs_readdata    = rdata_q;

  // ==========================================================================
  // shift enable: runs while every enabled path has work or room. run_q lags
  // shift_en by a cycle, so a path stops asking for tck in the cycle that
  // shifts its last bit; otherwise one pulse too many breaks alignment
  assign tx_last = run_q && tx_act_q && (tx_left_q == CNT_ONE);
  assign rx_last = run_q && rx_en && byte_end(cnt_q);

  always_comb begin
    tx_ready = !tx_en || tx_full_q || (tx_act_q && !tx_last);
    rx_ready = !rx_en || (!rx_full_q && !rx_last);
    shift_en = pri_q[PRI_TCK_EN] && tx_ready && rx_ready && (tx_en || rx_en);
  end

  // ==========================================================================
  // config, shifters and alignment counter
  always_comb begin
    pri_d     = pri_q;
    sec_d     = sec_q;
    ter_d     = ter_q;
    tx_hold_d = tx_hold_q;
    tx_full_d = tx_full_q;
    tx_sh_d   = tx_sh_q;
    tx_act_d  = tx_act_q;
    tx_left_d = tx_left_q;
    rx_sh_d   = rx_sh_q;
    rx_buf_d  = rx_buf_q;
    rx_full_d = rx_full_q;
    cnt_d     = cnt_q;
    run_d     = shift_en;
    viol_d    = viol_q;

    // a tck pulse occurs in the cycle run_q is high
    if (run_q) begin
      cnt_d = cnt_q + CNT_ONE;
      if (rx_en) begin
        // sample returning data on core_clk, targets drove it on tck fall;
        // tdi is timed by gated core_clk, so it is taken straight off the pin
        rx_sh_d = {tdi, rx_sh_q[7:1]};
        if (byte_end(cnt_q)) begin
          rx_buf_d  = {tdi, rx_sh_q[7:1]};
          rx_full_d = 1'b1;
        end
      end
      if (tx_act_q) begin
        tx_sh_d   = {1'b0, tx_sh_q[7:1]};
        tx_left_d = tx_left_q - CNT_ONE;
        if (tx_left_q == CNT_ONE) begin
          tx_act_d = 1'b0;
        end
      end
    end

    // reload tdo shifter at a byte boundary; a late start counts from cnt
    if (tx_en && tx_full_q && (!tx_act_d || (run_q && byte_end(cnt_q)))) begin
      tx_sh_d   = tx_hold_q;
      tx_act_d  = 1'b1;
      tx_full_d = 1'b0;
      // remaining bits to the next byte boundary: 8 - cnt
      tx_left_d = CNT_ZERO - cnt_d;
    end

    // bus writes; set by hardware wins over clear
    if (wr_pri) begin
      if (run_q && ((avs_writedata[7:0] ^ pri_q) & locked_pri) != 8'h00) begin
        viol_d = 1'b1;
      end
      pri_d = merge_lane(pri_q, avs_writedata[7:0], avs_byteenable[0]);
    end
    if (wr_sec) begin
      if (run_q && (avs_writedata[SEC_LOCK_HI:SEC_LOCK_LO]
                    != sec_q[SEC_LOCK_HI:SEC_LOCK_LO])) begin
        viol_d = 1'b1;
      end
      sec_d = merge_lane(sec_q, avs_writedata[7:0], avs_byteenable[0]);
    end
    if (wr_ter) begin
      if (run_q && avs_writedata[TER_LOCK] != ter_q[TER_LOCK]) begin
        viol_d = 1'b1;
      end
      ter_d = merge_lane(ter_q, avs_writedata[7:0], avs_byteenable[0]);
    end
    if (wr_tx && !tx_full_d) begin
      tx_hold_d = avs_writedata[7:0];
      tx_full_d = 1'b1;
    end
    // reading the status word frees the receive byte unless one lands now
    if (rd_st && !rx_last) begin
      rx_full_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pri_q     <= RST_CFG;
      sec_q     <= RST_CFG;
      ter_q     <= RST_CFG;
      tx_hold_q <= 8'h00;
      tx_full_q <= 1'b0;
      tx_sh_q   <= 8'h00;
      tx_act_q  <= 1'b0;
      tx_left_q <= CNT_ZERO;
      rx_sh_q   <= 8'h00;
      rx_buf_q  <= 8'h00;
      rx_full_q <= 1'b0;
      cnt_q     <= CNT_ZERO;
      run_q     <= 1'b0;
      viol_q    <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      bus_q     <= SSA_BUS_IDLE;
    end else begin
      pri_q     <= pri_d;
      sec_q     <= sec_d;
      ter_q     <= ter_d;
      tx_hold_q <= tx_hold_d;
      tx_full_q <= tx_full_d;
      tx_sh_q   <= tx_sh_d;
      tx_act_q  <= tx_act_d;
      tx_left_q <= tx_left_d;
      rx_sh_q   <= rx_sh_d;
      rx_buf_q  <= rx_buf_d;
      rx_full_q <= rx_full_d;
      cnt_q     <= cnt_d;
      run_q     <= run_d;
      viol_q    <= viol_d;
      rdata_q   <= rdata_d;
      bus_q     <= bus_d;
    end
  end

  // ==========================================================================
  // outputs
  assign tdo            = tx_sh_q[0];
  assign lock_violation = viol_q;

endmodule

// ### verification/ssa_shift_align_asserts.sv
// Purpose: port-level checks of the shift alignment block
// Assumes: core_clk is the only clock
// Notes:   bound to every ssa_shift_align instance
`timescale 1ns/1ps
// ====================
// checker
module ssa_shift_align_chk
  import ssa_pkg::*;
(
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst_b,
  // bus
  input wire logic [ssa_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [ssa_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                       avs_waitrequest,
  // scan side
  input wire logic                       tck,
  input wire logic                       lock_violation
);
  // sampled at the rise, tck shows the low phase of core_clk
  a_tck_low_phase: assert property (@(posedge core_clk) disable iff (!rst_b) !tck)
    else $error("tck high while core_clk low");
  a_reset_quiet: assert property (@(negedge core_clk) disable iff (!rst_b)
    $rose(rst_b) |-> !tck ##1 !tck)
    else $error("tck runs right after reset");
  a_wait_one_cycle: assert property (@(posedge core_clk) disable iff (!rst_b)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == UNMAPPED_DATA)
    else $error("unmapped read not zero");
  a_lock_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
    lock_violation |=> lock_violation)
    else $error("lock flag dropped");
  a_lock_cause: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(lock_violation) |-> $past(avs_write))
    else $error("lock flag set without a write");
  // tck pulses since reset, never cleared between bursts, counted modulo one byte
  logic [CNT_W-1:0] burst_q;
  always_ff @(negedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      burst_q <= CNT_ZERO;
    end else if ($sampled(tck)) begin
      burst_q <= burst_q + CNT_ONE;
    end
  end
  a_burst_bytes: assert property (@(negedge core_clk) disable iff (!rst_b)
    $fell(tck) |-> burst_q == CNT_ZERO)
    else $error("tck burst not a whole byte");
  a_rdata_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
    !avs_read |=> $stable(avs_readdata))
    else $error("read data changed without a read");
endmodule

bind ssa_shift_align ssa_shift_align_chk u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tck(tck), .lock_violation(lock_violation));

// ### verification/ssa_scan_target.sv
// Purpose: behavioural scan chain target on the far side of the link
// Assumes: tck stands still between frames
// Notes:   bits enter at the top and leave from cell zero
`timescale 1ns/1ps
// ====================
// target chain
module ssa_scan_target #(parameter int LEN = 8) (
  // link
  input wire logic  tck,
  input wire logic  scan_in,
  output logic      scan_out,
  // observation
  output logic [LEN-1:0] cells_q,
  output int        pulses
);
  initial begin
    cells_q = '0;
    scan_out = 1'b0;
    pulses = 0;
  end
  always @(posedge tck) begin
    cells_q <= {scan_in, cells_q[LEN-1:1]};
    pulses <= pulses + 1;
  end
  always @(negedge tck) begin
    scan_out <= cells_q[0];
  end
endmodule

// ### verification/tb.sv
// Purpose: self-checking bench for the shift alignment block
// Assumes: one byte of the target chain
// Notes:   bytes leave and return lsb first
`timescale 1ns/1ps
// ====================
// bench
module tb;
  import ssa_pkg::*;
  logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest, tck, tdo, tdi, lock_violation;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, q;
  logic [3:0]        avs_byteenable;
  logic [7:0]        cells;
  int                pulses, err_count, checks;

  ssa_shift_align dut (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tck(tck), .tdo(tdo), .tdi(tdi),
    .lock_violation(lock_violation));
  ssa_scan_target #(.LEN(8)) u_target (.tck(tck), .scan_in(tdo), .scan_out(tdi),
    .cells_q(cells), .pulses(pulses));

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus answer", 32'h0, {31'h0, avs_waitrequest});
    @(posedge core_clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // polls status until the test clock has stopped
  task automatic wait_stop();
    int n;
    n = 0;
    repeat (3) @(posedge core_clk);
    do begin
      bus(1'b0, OFS_STATUS, 32'h0, q);
      n++;
    end while (q[ST_TCK_ON] !== 1'b0 && n < 40);
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    err_count = 0;
    checks = 0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, OFS_PRIMARY, 32'h0, q);
    chk("primary reset", 32'h0, q & 32'h0000_00FF);
    bus(1'b1, OFS_SECONDARY, 32'h0000_00A5, q);
    bus(1'b0, OFS_SECONDARY, 32'h0, q);
    chk("secondary", 32'h0000_00A5, q & 32'h0000_00FF);
    bus(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", UNMAPPED_DATA, q);
    bus(1'b1, OFS_TX_DATA, 32'h0000_005A, q);
    bus(1'b1, OFS_PRIMARY, 32'h0000_0019, q);
    wait_stop();
    chk("target byte", 32'h0000_005A, {24'h0, cells});
    chk("tck pulses", 32'h8, 32'(pulses));
    bus(1'b1, OFS_TX_DATA, 32'h0000_00C3, q);
    wait_stop();
    chk("rx byte", 32'h0000_005A, {24'h0, q[ST_RX_HI:ST_RX_LO]});
    chk("alignment count", 32'h0, {29'h0, q[ST_CNT_HI:ST_CNT_LO]});
    chk("second byte", 32'h0000_00C3, {24'h0, cells});
    chk("tck pulses", 32'h10, 32'(pulses));
    chk("lock idle", 32'h0, {31'h0, lock_violation});
    bus(1'b1, OFS_TX_DATA, 32'h0000_000F, q);
    bus(1'b1, OFS_PRIMARY, 32'h0000_0039, q);
    wait_stop();
    chk("lock flag", 32'h1, {31'h0, lock_violation});
    chk("third byte", 32'h0000_000F, {24'h0, cells});
    bus(1'b0, OFS_PRIMARY, 32'h0, q);
    chk("primary running write", 32'h0000_0039, q & 32'h0000_00FF);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("tdi level", 32'h1, {31'h0, q[ST_TDI_PIN]});
    chk("final count", 32'h0, {29'h0, q[ST_CNT_HI:ST_CNT_LO]});
    tally_and_finish();
  end
endmodule
